// File: include/host_port_pkg.sv
// Functional notes
// - Bus width comes from a strap caught at reset; shown in config bit 2.
// - Halves may come in either order; DWORD is committed only after both.
// - A second write to the pending half is dropped; nothing is committed.
// - A read pair is two halves; a repeated half restarts pairing next read.
// - Upper sixteen data lines are never driven in 16-bit mode.
// - Endian select is taken with each access; low little, high big endian.
// - Endian choice applies per access, for registers and FIFOs alike.
// - Internal path is 32-bit little endian, byte 3 in bits 31:24.
// - Word swap setting changes half-word mapping for registers and FIFOs.
// - In 32-bit mode word swap is ignored; upper lines map to upper half when little endian.
// - Writes swap words then reorder bytes; reads reorder then swap.
// - 32-bit lanes carry bytes 3,2,1,0 little endian, 0,1,2,3 big endian.
// - Unswapped 16-bit lanes follow the A1 and endian byte table.
// - With swap all ones, the 16-bit half selection is inverted.
package host_port_pkg;

  // ----------------------------------------------------------------
  // Widths, offsets and reset values
  // ----------------------------------------------------------------
  localparam int          HOST_AW          = 8;
  localparam int          WB_AW            = 8;
  localparam logic [7:0]  REG_HARDWARE_CONFIG_REGISTER       = 8'h00;
  localparam logic [7:0]  REG_WORD_SWAP    = 8'h04;
  localparam logic [7:0]  REG_PAIR_STAT    = 8'h08;
  localparam int          HARDWARE_CONFIG_REGISTER_WIDTH_BIT = 2;
  localparam logic [31:0] WORD_SWAP_RST    = 32'h0000_0000;
  localparam logic [31:0] WORD_SWAP_ALL    = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // Carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [HOST_AW-1:0] addr;
    logic               fifo_sel;
    logic               end_sel;
    logic [31:0]        wdata;
  } host_req_type;

  typedef struct packed {
    logic [HOST_AW-1:0] addr;
    logic               fifo_sel;
    logic               we;
    logic [31:0]        wdata;
  } int_req_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } port_state_type;

  // Byte reversal of a half-word and of a word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

endpackage

// File: rtl/strap_capture.sv
`timescale 1ns/1ns
module strap_capture
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Strap pin and captured level
  input  wire logic strap_i,
  output wire logic mode32_o
);

  logic mode_ff;
  logic nxt_mode;

  // Follow the strap while reset is held, freeze it after release
  always_comb begin
    nxt_mode = rst_i ? strap_i : mode_ff;
  end

  always_ff @(posedge clk_i) begin
    mode_ff <= nxt_mode;
  end

  assign mode32_o = mode_ff;

endmodule // strap_capture

// File: rtl/lane_mapper.sv
`timescale 1ns/1ns
module lane_mapper
  import host_port_pkg::*;
(
  // Access attributes
  input  wire logic        mode32_i,
  input  wire logic        end_sel_i,
  input  wire logic        swap_on_i,
  input  wire logic        a1_i,
  // Data in both directions
  input  wire logic [31:0] host_wdata_i,
  input  wire logic [31:0] int_rdata_i,
  output      logic [31:0] wr_word_o,
  output      logic [31:0] rd_word_o
);

  logic        hi;
  logic [15:0] wv;
  logic [15:0] rh;

  // A1, swap and endian together pick the half, endian reverses bytes; the read path is
  // the exact inverse, so one half select serves both directions
  always_comb begin
    hi = a1_i ^ swap_on_i ^ end_sel_i;
    wv = end_sel_i ? rev16(host_wdata_i[15:0]) : host_wdata_i[15:0];
    rh = hi ? int_rdata_i[31:16] : int_rdata_i[15:0];
    if (mode32_i) begin
      wr_word_o = end_sel_i ? rev32(host_wdata_i) : host_wdata_i;
      rd_word_o = end_sel_i ? rev32(int_rdata_i) : int_rdata_i;
    end else begin
      wr_word_o = hi ? {wv, 16'h0000} : {16'h0000, wv};
      rd_word_o = {16'h0000, end_sel_i ? rev16(rh) : rh};
    end
  end

endmodule // lane_mapper

// File: rtl/host_bus_width_endian_swap.sv
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ns
module host_bus_width_endian_swap
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Width strap
  input  wire logic               bus_width_strap_i,
  // Host access port
  input  wire host_req_type       host_req_i,
  input  wire logic               host_wr_stb_i,
  input  wire logic               host_rd_stb_i,
  input  wire logic               host_oe_i,
  output wire logic [31:0]        host_data_o,
  output wire logic [31:0]        host_data_oe_o,
  output wire logic               host_done_o,
  // Internal 32-bit bus
  output wire int_req_type        int_req_o,
  output wire logic               int_stb_o,
  input  wire logic [31:0]        int_rdata_i,
  input  wire logic               int_ack_i,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [WB_AW-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output wire logic [31:0]        wb_dat_o,
  output wire logic               wb_ack_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic           mode32;
  logic           swap_on;
  host_req_type   map_req;
  logic [31:0]    map_rdata;
  logic [31:0]    wr_word;
  logic [31:0]    rd_word;

  port_state_type state_ff,   nxt_state;
  host_req_type   cur_ff,     nxt_cur;
  int_req_type    ireq_ff,    nxt_ireq;
  logic           istb_ff,    nxt_istb;
  logic           wpend_ff,   nxt_wpend;
  logic           wa1_ff,     nxt_wa1;
  logic [5:0]     wdw_ff,     nxt_wdw;
  logic [31:0]    wbuf_ff,    nxt_wbuf;
  logic           rpend_ff,   nxt_rpend;
  logic [5:0]     rdw_ff,     nxt_rdw;
  logic [31:0]    rbuf_ff,    nxt_rbuf;
  logic [31:0]    dout_ff,    nxt_dout;
  logic           done_ff,    nxt_done;

  logic           ack_ff,     nxt_ack;
  logic [31:0]    wbdat_ff,   nxt_wbdat;
  logic [31:0]    swap_ff,    nxt_swap;

  logic           w_same_dw;
  logic           r_same_dw;

  // ----------------------------------------------------------------
  // Width strap and byte lane mapping
  // ----------------------------------------------------------------
  strap_capture u_strap (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .strap_i  (bus_width_strap_i),
    .mode32_o (mode32)
  );

  // Swap only counts when every bit is set, and never in 32-bit mode
  assign swap_on = (swap_ff == WORD_SWAP_ALL) && !mode32;

  // New strobes map the live request; a pending read maps the stored one
  assign map_req   = (state_ff == ST_IDLE) ? host_req_i : cur_ff;
  assign map_rdata = (state_ff == ST_IDLE) ? rbuf_ff : int_rdata_i;

  lane_mapper u_map (
    .mode32_i     (mode32),
    .end_sel_i    (map_req.end_sel),
    .swap_on_i    (swap_on),
    .a1_i         (map_req.addr[1]),
    .host_wdata_i (map_req.wdata),
    .int_rdata_i  (map_rdata),
    .wr_word_o    (wr_word),
    .rd_word_o    (rd_word)
  );

  assign w_same_dw = wpend_ff && (wdw_ff == host_req_i.addr[7:2]);
  assign r_same_dw = rpend_ff && (rdw_ff == host_req_i.addr[7:2]);

  // ----------------------------------------------------------------
  // Host access sequencer
  // ----------------------------------------------------------------
  // Strobes are only taken in idle; the host waits for done first
  always_comb begin
    nxt_state = state_ff;
    nxt_cur   = cur_ff;
    nxt_ireq  = ireq_ff;
    nxt_istb  = istb_ff;
    nxt_wpend = wpend_ff;
    nxt_wa1   = wa1_ff;
    nxt_wdw   = wdw_ff;
    nxt_wbuf  = wbuf_ff;
    nxt_rpend = rpend_ff;
    nxt_rdw   = rdw_ff;
    nxt_rbuf  = rbuf_ff;
    nxt_dout  = dout_ff;
    nxt_done  = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (host_wr_stb_i) begin
          nxt_cur = host_req_i;
          if (mode32) begin
            nxt_ireq  = '{host_req_i.addr, host_req_i.fifo_sel, 1'b1, wr_word};
            nxt_istb  = 1'b1;
            nxt_state = ST_WRITE;
          end else if (w_same_dw && (host_req_i.addr[1] == wa1_ff)) begin
            // Same half again: drop it, the first half stays pending
            nxt_done = 1'b1;
          end else if (w_same_dw) begin
            // Other half arrived: merge and commit one DWORD
            nxt_ireq  = '{host_req_i.addr, host_req_i.fifo_sel, 1'b1,
                          wbuf_ff | wr_word};
            nxt_istb  = 1'b1;
            nxt_wpend = 1'b0;
            nxt_state = ST_WRITE;
          end else begin
            // First half, or a new DWORD address restarts the pair
            nxt_wbuf  = wr_word;
            nxt_wpend = 1'b1;
            nxt_wa1   = host_req_i.addr[1];
            nxt_wdw   = host_req_i.addr[7:2];
            nxt_done  = 1'b1;
          end
        end else if (host_rd_stb_i) begin
          nxt_cur = host_req_i;
          if (!mode32 && r_same_dw) begin
            // Second read is served from the latch; either half closes
            // the pair, so a repeated half starts afresh next time
            nxt_dout  = rd_word;
            nxt_rpend = 1'b0;
            nxt_done  = 1'b1;
          end else begin
            nxt_ireq  = '{host_req_i.addr, host_req_i.fifo_sel, 1'b0, 32'h0000_0000};
            nxt_istb  = 1'b1;
            nxt_state = ST_READ;
          end
        end
      end
      ST_WRITE: begin
        if (int_ack_i) begin
          nxt_istb  = 1'b0;
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_READ: begin
        if (int_ack_i) begin
          nxt_istb  = 1'b0;
          nxt_done  = 1'b1;
          nxt_dout  = rd_word;
          nxt_rbuf  = int_rdata_i;
          nxt_rpend = !mode32;
          nxt_rdw   = cur_ff.addr[7:2];
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cur_ff   <= '0;
      ireq_ff  <= '0;
      istb_ff  <= 1'b0;
      wpend_ff <= 1'b0;
      wa1_ff   <= 1'b0;
      wdw_ff   <= 6'h00;
      wbuf_ff  <= 32'h0000_0000;
      rpend_ff <= 1'b0;
      rdw_ff   <= 6'h00;
      rbuf_ff  <= 32'h0000_0000;
      dout_ff  <= 32'h0000_0000;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cur_ff   <= nxt_cur;
      ireq_ff  <= nxt_ireq;
      istb_ff  <= nxt_istb;
      wpend_ff <= nxt_wpend;
      wa1_ff   <= nxt_wa1;
      wdw_ff   <= nxt_wdw;
      wbuf_ff  <= nxt_wbuf;
      rpend_ff <= nxt_rpend;
      rdw_ff   <= nxt_rdw;
      rbuf_ff  <= nxt_rbuf;
      dout_ff  <= nxt_dout;
      done_ff  <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // Host pins and internal bus
  // ----------------------------------------------------------------
  // Upper lanes stay released in 16-bit mode; the pad pull-downs hold them
  assign host_data_oe_o = host_oe_i ? {{16{mode32}}, 16'hFFFF} : 32'h0000_0000;
  assign host_data_o    = dout_ff;
  assign host_done_o    = done_ff;
  assign int_req_o      = ireq_ff;
  assign int_stb_o      = istb_ff;

  // ----------------------------------------------------------------
  // Wishbone register slave
  // ----------------------------------------------------------------
  // One wait state: ack rises the edge after the request, drops next
  always_comb begin
    nxt_ack   = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_swap  = swap_ff;
    nxt_wbdat = 32'h0000_0000;
    if (nxt_ack && wb_we_i && (wb_adr_i == REG_WORD_SWAP)) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          nxt_swap[8*i +: 8] = wb_dat_i[8*i +: 8];
        end
      end
    end
    if (nxt_ack && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_HARDWARE_CONFIG_REGISTER:    nxt_wbdat[HARDWARE_CONFIG_REGISTER_WIDTH_BIT] = mode32;
        REG_WORD_SWAP: nxt_wbdat = swap_ff;
        REG_PAIR_STAT: nxt_wbdat = {30'h0000_0000, rpend_ff, wpend_ff};
        default:       nxt_wbdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      wbdat_ff <= 32'h0000_0000;
      swap_ff  <= WORD_SWAP_RST;
    end else begin
      ack_ff   <= nxt_ack;
      wbdat_ff <= nxt_wbdat;
      swap_ff  <= nxt_swap;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = wbdat_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_upper_float: assert property (
    @(posedge clk_i) disable iff (rst_i) !mode32 |-> host_data_oe_o[31:16] == 16'h0000)
    else $error("upper lanes driven in 16-bit mode");

  a_hwcfg_width: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (nxt_ack && !wb_we_i && wb_adr_i == REG_HARDWARE_CONFIG_REGISTER)
    |=> wb_ack_o && wb_dat_o[2] == mode32)
    else $error("width bit wrong in config read");

  a_same_drop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_wr_stb_i && !mode32 && w_same_dw
     && host_req_i.addr[1] == wa1_ff)
    |=> state_ff == ST_IDLE && !int_stb_o && wpend_ff && host_done_o)
    else $error("repeated half write was not dropped");

  a_pair_commit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_wr_stb_i && !mode32 && w_same_dw
     && host_req_i.addr[1] != wa1_ff)
    |=> int_stb_o && int_req_o.we && !wpend_ff
        && int_req_o.wdata == ($past(wbuf_ff) | $past(wr_word)))
    else $error("paired halves not committed");

  a_read_restart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_rd_stb_i && !host_wr_stb_i && !mode32 && r_same_dw)
    |=> !rpend_ff && !int_stb_o ##1 !host_done_o)
    else $error("read pair not closed");

  a_lane32_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_wr_stb_i && mode32)
    |=> int_req_o.wdata == ($past(host_req_i.end_sel)
                            ? rev32($past(host_req_i.wdata)) : $past(host_req_i.wdata)))
    else $error("32-bit lane order wrong");

  a_half_plain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_wr_stb_i && !mode32 && !wpend_ff && !swap_on
     && host_req_i.end_sel && host_req_i.addr[1])
    |=> wbuf_ff == {16'h0000, rev16($past(host_req_i.wdata[15:0]))})
    else $error("unswapped half placement wrong");

  a_half_swap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_wr_stb_i && !mode32 && !wpend_ff && swap_on
     && !host_req_i.end_sel && host_req_i.addr[1])
    |=> wbuf_ff == {16'h0000, $past(host_req_i.wdata[15:0])})
    else $error("swapped half placement wrong");

  // Width may only move while reset is held
  a_width_frozen: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> $stable(mode32))
    else $error("bus width changed outside reset");

  a_upper_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !mode32 |-> host_data_o[31:16] == 16'h0000)
    else $error("upper read lanes carry data in 16-bit mode");

  // A lone first half must never reach the internal bus
  a_first_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_IDLE && host_wr_stb_i && !mode32 && !w_same_dw)
    |=> !int_stb_o && wpend_ff && host_done_o)
    else $error("first half reached the internal bus");

  a_read32_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_READ && int_ack_i && mode32)
    |=> host_data_o == ($past(cur_ff.end_sel)
                        ? rev32($past(int_rdata_i)) : $past(int_rdata_i)))
    else $error("32-bit read lane order wrong");

  a_half_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_READ && int_ack_i && !mode32 && !swap_on
     && !cur_ff.end_sel && !cur_ff.addr[1])
    |=> host_data_o == {16'h0000, $past(int_rdata_i[15:0])})
    else $error("little endian low half read wrong");

  a_half_big: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == ST_READ && int_ack_i && !mode32 && !swap_on
     && cur_ff.end_sel && !cur_ff.addr[1])
    |=> host_data_o == {16'h0000, rev16($past(int_rdata_i[31:16]))})
    else $error("big endian high half read wrong");

endmodule // host_bus_width_endian_swap

// File: sim/int_bus_model.sv
`timescale 1ns/1ns
module int_bus_model
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Internal bus from the block
  input  wire int_req_type int_req_i,
  input  wire logic        int_stb_i,
  input  wire logic [3:0]  delay_i,
  output      logic [31:0] int_rdata_o,
  output      logic        int_ack_o
);
  // ----------------------------------------------------------------
  // Word store, one 32-bit little-endian word per DWORD address
  // ----------------------------------------------------------------
  logic [31:0] mem [64];
  logic [31:0] last_wr;
  logic [31:0] rd_ff;
  logic [3:0]  wait_cnt;
  logic        served;
  int          wr_cnt;
  int          rd_cnt;

  // Answer once per request after delay_i cycles; served blocks a double ack.
  // Plain always, since the bench preloads mem between transfers
  always @(posedge clk_i) begin
    int_ack_o <= 1'b0;
    if (rst_i || !int_stb_i) begin
      wait_cnt <= 4'h0;
      served   <= 1'b0;
    end else if (!served && wait_cnt == delay_i) begin
      int_ack_o <= 1'b1;
      served    <= 1'b1;
      if (int_req_i.we) begin
        mem[int_req_i.addr[7:2]] <= int_req_i.wdata;
        last_wr <= int_req_i.wdata;
        wr_cnt  <= wr_cnt + 1;
      end else begin
        rd_ff  <= mem[int_req_i.addr[7:2]];
        rd_cnt <= rd_cnt + 1;
      end
    end else if (!served) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Outside ack the data lines show the inverse, never a stale good value
  assign int_rdata_o = int_ack_o ? rd_ff : ~rd_ff;
endmodule // int_bus_model

// File: sim/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module testbench
  import host_port_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         strap = 1'b1;
  host_req_type hreq  = '0;
  logic         wr_stb = 1'b0;
  logic         rd_stb = 1'b0;
  logic         oe     = 1'b0;
  logic [31:0]  hdata, hoe, rdat, ird, wdat;
  logic         hdone, istb, iack, ack, cyc = 1'b0, we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [31:0]  wd  = 32'h0;
  logic [3:0]   dly = 4'h0;
  int_req_type  ireq;
  int           err_total = 0;
  int           comparisons = 0;

  host_bus_width_endian_swap dut_u (.clk_i(clk_i), .rst_i(rst_i), .bus_width_strap_i(strap),
    .host_req_i(hreq), .host_wr_stb_i(wr_stb), .host_rd_stb_i(rd_stb), .host_oe_i(oe),
    .host_data_o(hdata), .host_data_oe_o(hoe), .host_done_o(hdone), .int_req_o(ireq),
    .int_stb_o(istb), .int_rdata_i(ird), .int_ack_i(iack), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  int_bus_model part_u (.clk_i(clk_i), .rst_i(rst_i), .int_req_i(ireq), .int_stb_i(istb),
    .delay_i(dly), .int_rdata_o(ird), .int_ack_o(iack));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Bus tasks and reference byte order
  // ----------------------------------------------------------------
  function automatic logic [31:0] bs(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wd <= d;
    // No local limit: only the watchdog may end a wait
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    wdat = rdat;
    cyc <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask

  // One host access; waits for done with no local bound
  task automatic host(input logic w, input logic [7:0] a, input logic e, input logic [31:0] d);
    @(posedge clk_i);
    hreq <= '{addr: a, fifo_sel: e, end_sel: e, wdata: d};
    wr_stb <= w; rd_stb <= !w;
    @(posedge clk_i);
    wr_stb <= 1'b0; rd_stb <= 1'b0;
    while (hdone !== 1'b1) begin
      @(posedge clk_i);
    end
  endtask

  task automatic do_reset(input logic s);
    strap <= s; rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_mode32;
    logic [31:0] m;
    wb(1'b0, REG_HARDWARE_CONFIG_REGISTER, 32'h0); `CHK("cfg32", 1'b1, wdat[HARDWARE_CONFIG_REGISTER_WIDTH_BIT])
    wb(1'b0, 8'hFC, 32'h0); `CHK("unmapped", 32'h0, wdat)
    wb(1'b1, REG_WORD_SWAP, WORD_SWAP_ALL);
    wb(1'b0, REG_WORD_SWAP, 32'h0); `CHK("swap rb", WORD_SWAP_ALL, wdat)
    for (int e = 0; e < 2; e++) begin
      dly <= e ? 4'h3 : 4'h0;
      host(1'b1, 8'h10, e, 32'h1122_3344);
      m = e ? bs(32'h1122_3344) : 32'h1122_3344;
      `CHK("w32", m, part_u.last_wr)
      part_u.mem[5] = 32'hA1B2_C3D4;
      host(1'b0, 8'h14, e, 32'h0);
      m = e ? bs(32'hA1B2_C3D4) : 32'hA1B2_C3D4;
      `CHK("r32", m, hdata)
    end
    // In 32-bit mode every lane is driven while the host reads
    oe <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("oe32", 32'hFFFF_FFFF, hoe)
    @(posedge clk_i);
    oe <= 1'b0;
  endtask

  task automatic t_write16;
    logic [31:0] m;
    logic [15:0] d0, d1;
    int          c, h;
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, REG_WORD_SWAP, k[2] ? WORD_SWAP_ALL : WORD_SWAP_RST);
      d0 = 16'h1A2B + 16'(k);
      d1 = 16'hC3D4 + 16'(k);
      c = part_u.wr_cnt;
      host(1'b1, {6'h3, k[0], 1'b0}, k[1], {16'h0, d0});
      `CHK("w16 first", c, part_u.wr_cnt)
      host(1'b1, {6'h3, !k[0], 1'b0}, k[1], {16'h0, d1});
      `CHK("w16 pair", c + 1, part_u.wr_cnt)
      h = k[0] ^ k[2] ^ k[1];
      m[h*16 +: 16]     = k[1] ? {d0[7:0], d0[15:8]} : d0;
      m[(1-h)*16 +: 16] = k[1] ? {d1[7:0], d1[15:8]} : d1;
      `CHK("w16 word", m, part_u.last_wr)
    end
  endtask

  task automatic t_drop16;
    int c;
    wb(1'b1, REG_WORD_SWAP, WORD_SWAP_RST);
    c = part_u.wr_cnt;
    host(1'b1, 8'h20, 1'b0, 32'h0000_5566);
    host(1'b1, 8'h20, 1'b0, 32'h0000_7788);
    wb(1'b0, REG_PAIR_STAT, 32'h0);
    `CHK("drop pending", 32'h0000_0001, wdat)
    `CHK("drop count", c, part_u.wr_cnt)
    host(1'b1, 8'h22, 1'b0, 32'h0000_99AA);
    `CHK("drop word", 32'h99AA_5566, part_u.last_wr)
  endtask

  task automatic t_read16;
    int c;
    dly <= 4'h2;
    part_u.mem[9] = 32'h8877_6655;
    c = part_u.rd_cnt;
    host(1'b0, 8'h24, 1'b1, 32'h0);
    `CHK("r16 a1lo big", 32'h0000_7788, hdata)
    host(1'b0, 8'h26, 1'b1, 32'h0);
    `CHK("r16 a1hi big", 32'h0000_5566, hdata)
    `CHK("r16 one fetch", c + 1, part_u.rd_cnt)
    host(1'b0, 8'h24, 1'b0, 32'h0);
    part_u.mem[9] = 32'h1234_ABCD;
    host(1'b0, 8'h24, 1'b0, 32'h0);
    host(1'b0, 8'h24, 1'b0, 32'h0);
    `CHK("r16 fresh", 32'h0000_ABCD, hdata)
    `CHK("r16 refetch", c + 3, part_u.rd_cnt)
    oe <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK("upper oe", 32'h0000_FFFF, hoe)
    @(posedge clk_i);
    oe <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog of 20000 cycles, well beyond the few hundred cycles the scenarios need
  initial begin
    #400000;
    err_total++;
    test_done();
  end

  initial begin
    do_reset(1'b1);
    t_mode32();
    do_reset(1'b0);
    wb(1'b0, REG_HARDWARE_CONFIG_REGISTER, 32'h0); `CHK("cfg16", 1'b0, wdat[HARDWARE_CONFIG_REGISTER_WIDTH_BIT])
    t_write16();
    t_drop16();
    t_read16();
    test_done();
  end
endmodule // testbench
